/* File: src/eofm_consts.vh */
// Constants for the external oscillator fail monitor register block.
// Assumes a 32-bit Wishbone classic slave with word-aligned byte addresses.
`ifndef EOFM_CONSTS_VH
`define EOFM_CONSTS_VH

// Register byte offsets
`define EOFM_CTRL_OFS         8'h00
`define EOFM_MAINCNT_OFS      8'h04
// Field positions of the control/status register
`define EOFM_BIT_MCLK_PRESENT 4
`define EOFM_BIT_MON_EN       3
`define EOFM_BIT_IRQ_EN       2
`define EOFM_BIT_FAIL_FLAG    1
`define EOFM_BIT_OSC_RUN      0
// Reset values
`define EOFM_MON_EN_RST       1'b0
`define EOFM_IRQ_EN_RST       1'b0
// Loss-of-oscillation timeout in core clock cycles (no edge seen)
`define EOFM_LOSS_CYCLES      16'h0040
// Main clock presence timeout in core clock cycles
`define EOFM_MCLK_CYCLES      16'h0040

`endif

/* File: src/eofm_edge_watch.v */
// Activity watchdog: reports whether a sampled clock-like input toggles.
// Assumes the watched input is already synchronous to core_clk.
module eofm_edge_watch #(
    parameter [15:0] TIMEOUT = 16'h0040
) (
    // Clock and reset
    input  wire core_clk,
    input  wire arst_n,
    // Watched input and result
    input  wire sig_in,
    output reg  alive_q
);
    reg        prev_q;   // Last sample of the input
    reg [15:0] cnt_q;    // Cycles since last edge

    // Restart count on any edge, flag dead when count runs out
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_q  <= 1'b0;
            cnt_q   <= 16'h0000;
            alive_q <= 1'b0;
        end else begin
            prev_q <= sig_in;
            if (sig_in != prev_q) begin
                // Edge seen
                cnt_q   <= 16'h0000;
                alive_q <= 1'b1;
            end else if (cnt_q >= TIMEOUT) begin
                // Quiet too long
                alive_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end
endmodule // eofm_edge_watch

/* File: src/eofm_top.v */
// External oscillator fail monitor: Wishbone control/status register.
// Assumes osc_sample and mclk_sample are synchronous samples of the clocks.
// Register image at the control offset (one 32-bit word):
//   bit 4  main clock present, live, read only
//   bit 3  supervision enable, read/write
//   bit 2  failure interrupt enable, read/write
//   bit 1  failure pending, read, write one to clear
//   bit 0  oscillator running, live, read only
//   bits 31:5 read as zero, writes to them are dropped
//
// Failure criterion: the oscillator counts as lost once its sampled
// level has not changed for LOSS_CYCLES + 1 core clocks. The event is the
// fall of the running status, so a stopped oscillator raises the flag
// once only; software clearing the flag while the oscillator is still
// dead does not bring it back.
//
// Hazards kept in mind:
//   - A loss event and a write-one-clear in the same cycle: the set wins,
//     so no failure can be lost between a read and the acknowledging write.
//   - Turning supervision on while the oscillator is already dead does not
//     flag anything; only a fresh loss does.
//   - The interrupt request is a level that follows the flag and enable,
//     registered so that it leaves the block straight from a flip-flop.
//
// Bus behaviour: every access is acknowledged one cycle after it is
// taken, whether mapped or not, and ack drops for a cycle after each
// answer even when the master keeps its strobe up.
//
// Implementation choices: the Wishbone register port and the register offsets.
`include "eofm_consts.vh"
module eofm_top #(
    parameter [15:0] LOSS_CYCLES = `EOFM_LOSS_CYCLES,
    parameter [15:0] MCLK_CYCLES = `EOFM_MCLK_CYCLES
) (
    // Clock and reset
    input  wire        core_clk,
    input  wire        arst_n,
    // Wishbone classic slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Supervised clocks, sampled
    input  wire        osc_sample,
    input  wire        mclk_sample,
    // Interrupt request
    output reg         osc_fail_irq
);
    reg  osc_monitor_enable_q;   // Supervision on
    reg  osc_fail_irq_enable_q;  // Interrupt on
    reg  osc_fail_event_flag_q;  // Pending failure
    reg  osc_run_prev_q;         // Last running state
    wire osc_running_status;     // Live oscillator state
    wire main_clock_present_status; // Live main clock state
    wire osc_lost;               // Falling running status
    wire wr_req;                 // Write taken this cycle
    wire ctrl_hit;               // Address is control register
    wire [31:0] rd_word;         // Read mux result
    reg  fail_flag_d;            // Next flag value
    wire ctrl_wr_hit;            // Lane 0 write to control register
    wire rd_req;                 // Read taken this cycle

    // Decode a write that reaches the low byte of the control register
    function ctrl_lane0_write;
        input       req;         // Write request taken
        input [7:0] adr;         // Byte address
        input       sel0;        // Lane 0 select
        begin
            // Only the low byte carries bits; other lanes are ignored
            ctrl_lane0_write = req && (adr == `EOFM_CTRL_OFS) && sel0;
        end
    endfunction

    // Pack live and stored bits into the register image
    function [31:0] pack_ctrl_word;
        input mclk_present;      // Main clock seen
        input mon_en;            // Supervision on
        input irq_en;            // Interrupt on
        input fail_flag;         // Pending failure
        input osc_run;           // Oscillator seen
        begin
            // Unused upper bits stay zero
            pack_ctrl_word = 32'h00000000;
            pack_ctrl_word[`EOFM_BIT_MCLK_PRESENT] = mclk_present;
            pack_ctrl_word[`EOFM_BIT_MON_EN]       = mon_en;
            pack_ctrl_word[`EOFM_BIT_IRQ_EN]       = irq_en;
            pack_ctrl_word[`EOFM_BIT_FAIL_FLAG]    = fail_flag;
            pack_ctrl_word[`EOFM_BIT_OSC_RUN]      = osc_run;
        end
    endfunction

    // Oscillator activity watch
    eofm_edge_watch #(.TIMEOUT(LOSS_CYCLES)) u_osc_watch (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .sig_in   (osc_sample),
        .alive_q  (osc_running_status)
    );

    // Main clock activity watch
    eofm_edge_watch #(.TIMEOUT(MCLK_CYCLES)) u_mclk_watch (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .sig_in   (mclk_sample),
        .alive_q  (main_clock_present_status)
    );

    assign osc_lost = osc_run_prev_q & ~osc_running_status;
    // Single-cycle answer; no ack while previous ack high
    assign wr_req   = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
    // Read taken this cycle, same single-cycle rule as writes
    assign rd_req   = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
    // Address decode of the one mapped word
    assign ctrl_hit = (wb_adr_i == `EOFM_CTRL_OFS);
    // Write that actually lands in the control bits
    assign ctrl_wr_hit = ctrl_lane0_write(wr_req, wb_adr_i, wb_sel_i[0]);

    // Read word assembly; unmapped reads zero
    // Live status bits and stored control bits
    assign rd_word = ctrl_hit ? pack_ctrl_word(main_clock_present_status,
                                               osc_monitor_enable_q,
                                               osc_fail_irq_enable_q,
                                               osc_fail_event_flag_q,
                                               osc_running_status)
                              : 32'h00000000;

    // Next fail flag: set beats clear
    always @* begin
        fail_flag_d = osc_fail_event_flag_q;
        if (ctrl_wr_hit && wb_dat_i[`EOFM_BIT_FAIL_FLAG])
            fail_flag_d = 1'b0;
        if (osc_monitor_enable_q && osc_lost)
            fail_flag_d = 1'b1;
    end

    // Control bits, flag and bus answer
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            osc_monitor_enable_q  <= `EOFM_MON_EN_RST;
            osc_fail_irq_enable_q <= `EOFM_IRQ_EN_RST;
            osc_fail_event_flag_q <= 1'b0;
            osc_run_prev_q        <= 1'b0;
            osc_fail_irq          <= 1'b0;
            wb_ack_o              <= 1'b0;
            wb_dat_o              <= 32'h00000000;
        end else begin
            osc_run_prev_q <= osc_running_status;
            osc_fail_event_flag_q <= fail_flag_d;
            // Ack every access, mapped or not
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            // Read data stands only in the ack cycle, zero otherwise
            wb_dat_o <= rd_req ? rd_word : 32'h00000000;
            // Enables follow the written low byte
            if (ctrl_wr_hit) begin
                osc_monitor_enable_q  <= wb_dat_i[`EOFM_BIT_MON_EN];
                osc_fail_irq_enable_q <= wb_dat_i[`EOFM_BIT_IRQ_EN];
            end
            osc_fail_irq <= fail_flag_d & osc_fail_irq_enable_q;
        end
    end
endmodule // eofm_top

/* File: tb/eofm_top_assertions.sv */
// Checker for eofm_top: bus handshake and status bit relations.
// Assumes a Wishbone master that holds its request until ack.
module eofm_top_assertions #(
    parameter [15:0] LOSS_CYCLES = 16'h0040, MCLK_CYCLES = 16'h0040) (
    input wire logic core_clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, osc_sample, mclk_sample,
    input wire logic [7:0] wb_adr_i, input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i, wb_dat_o, input wire logic wb_ack_o, osc_fail_irq);
    logic [15:0] qo_q, qm_q; // Quiet cycle counts
    logic        po_q, pm_q, me_q, ie_q; // Last samples, shadow enables
    wire rd0 = wb_ack_o && !wb_we_i && wb_adr_i == 8'h00;
    wire wr0 = wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Track quiet spans and written enables
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            {qo_q, qm_q, po_q, pm_q, me_q, ie_q} <= '0;
        end else begin
            po_q <= osc_sample;
            pm_q <= mclk_sample;
            qo_q <= (osc_sample != po_q) ? 16'h0000 : qo_q + {15'h0000, ~&qo_q};
            qm_q <= (mclk_sample != pm_q) ? 16'h0000 : qm_q + {15'h0000, ~&qm_q};
            if (wr0) {me_q, ie_q} <= wb_dat_i[3:2];
        end
    end
    a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_ctl_readback: assert property (rd0 |-> wb_dat_o[3:2] == {me_q, ie_q})
        else $error("enable readback wrong");
    a_irq_gate: assert property (osc_fail_irq |-> ie_q)
        else $error("irq without enable");
    a_osc_dead: assert property (rd0 && qo_q > LOSS_CYCLES + 16'h4 |-> !wb_dat_o[0])
        else $error("osc status high");
    a_mclk_dead: assert property (rd0 && qm_q > MCLK_CYCLES + 16'h4 |-> !wb_dat_o[4])
        else $error("main clock status high");
    a_clear_w1c: assert property (wr0 && wb_dat_i[1] && qo_q > LOSS_CYCLES + 16'h4 |=> !osc_fail_irq)
        else $error("irq not cleared");
    cover property (osc_fail_irq);
    cover property (wr0 && wb_dat_i[1]);
    cover property (rd0 && wb_dat_o[0]);
endmodule // eofm_top_assertions
bind eofm_top eofm_top_assertions #(.LOSS_CYCLES(LOSS_CYCLES), .MCLK_CYCLES(MCLK_CYCLES)) u_chk (.*);

/* File: tb/eofm_osc_model.sv */
// Behavioural oscillator outside the monitor.
// Assumes core_clk sampling; the level freezes when stopped.
module eofm_osc_model (
    input wire logic core_clk, run, // Clock, run control
    output logic     clk_out // Sampled oscillator level
);
    timeunit 1ns;
    timeprecision 1ns;
    initial clk_out = 1'b0;
    // Toggle every cycle while running
    always @(posedge core_clk) if (run) clk_out <= ~clk_out;
endmodule // eofm_osc_model

/* File: tb/eofm_top_test.sv */
// Testbench for eofm_top: register steps with oscillator stops.
// Assumes short loss timeouts of 8 cycles.
module eofm_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, arst_n = 0, cyc = 0, stb = 0, we = 0, osc_run = 0, mclk_run = 0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] dat = 32'h0, rd, wb_dat_o;
    logic wb_ack_o, irq, osc_s, mclk_s;
    int n_mismatch = 0, samples_checked = 0;
    // Step table: runs, written value, expected read
    logic [19:0] tbl[9] = '{20'h30011, 20'h30C1D, 20'h10C1E, 20'h10E1C, 20'h30819,
                            20'h1081A, 20'h10614, 20'h20405, 20'h00404};
    always #5 core_clk = ~core_clk;
    eofm_top #(.LOSS_CYCLES(16'h0008), .MCLK_CYCLES(16'h0008)) i_dut (.core_clk(core_clk),
        .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .osc_sample(osc_s), .mclk_sample(mclk_s), .osc_fail_irq(irq));
    eofm_osc_model i_osc (.core_clk(core_clk), .run(osc_run), .clk_out(osc_s));
    eofm_osc_model i_mclk (.core_clk(core_clk), .run(mclk_run), .clk_out(mclk_s));
    // One classic bus cycle, waits for ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
        do begin @(posedge core_clk); n++; end while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1) begin n_mismatch++; $display("[FAIL] ack exp 1 got %b", wb_ack_o); end
        rd = wb_dat_o;
        cyc <= 0; stb <= 0;
        @(posedge core_clk);
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin n_mismatch++; $display("[FAIL] %s exp %h got %h", s, e, g); end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Watchdog
    initial begin repeat (5000) @(posedge core_clk); n_mismatch++; give_verdict; end
    // Main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        arst_n <= 1;
        foreach (tbl[i]) begin
            {osc_run, mclk_run} <= tbl[i][17:16];
            repeat (20) @(posedge core_clk);
            wb(1, 8'h00, {24'h0, tbl[i][15:8]});
            wb(0, 8'h00, 32'h0);
            chk("ctrl", {24'h0, tbl[i][7:0]}, rd);
            chk("irq", {31'h0, tbl[i][2] & tbl[i][1]}, {31'h0, irq});
        end
        sel <= 4'hE;
        wb(1, 8'h00, 32'h0);
        sel <= 4'hF;
        wb(0, 8'h00, 32'h0);
        chk("lane0", 32'h4, rd);
        wb(1, 8'h04, 32'hFF);
        wb(0, 8'h04, 32'h0);
        chk("unmapped", 32'h0, rd);
        give_verdict;
    end
endmodule // eofm_top_test
